// ===== core/spp_core.sv
// Stereo pair processor with a parameterised output FIFO.
`timescale 1ns/1ps

// Output FIFO with valid and ready on both sides.
module spp_fifo
  import spp_pkg::*;
#(
  parameter int WIDTH = 2 * SPP_SAMPLE_W,
  parameter int DEPTH = SPP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count. The count is one
  // bit wider than the pointers so that full and empty never alias.
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // Storage is written without reset; only the pointers and the count need a defined state.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Occupancy checks; an overrun here would overwrite a stored pair.
  property p_fill_level;
    @(posedge sys_clk) disable iff (rst)
      cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_fill_level: assert property (p_fill_level)
    else $error("buffer holds more pairs than it has room for");

  property p_full_refuse;
    @(posedge sys_clk) disable iff (rst)
      push && !pop && cnt_q == (AW+1)'(DEPTH - 1) |=> !in_ready;
  endproperty
  a_full_refuse: assert property (p_full_refuse)
    else $error("buffer kept accepting once full");

endmodule // spp_fifo

// Per-channel chooser; one copy serves each channel of the pair.
module spp_pick
  import spp_pkg::*;
#(
  parameter int SAMPLE_W = SPP_SAMPLE_W
) (
  input wire spp_mode_t mode,
  input wire logic signed [SAMPLE_W-1:0] own,
  input wire logic signed [SAMPLE_W-1:0] partner,
  input wire logic signed [SAMPLE_W-1:0] half_sum,
  input wire logic signed [SAMPLE_W-1:0] half_diff,
  output logic signed [SAMPLE_W-1:0] res
);
  // Every code of the two-bit setting is legal, so no default is needed.
  always_comb begin
    unique case (mode)
      SPP_MODE_PASS: res = own;
      SPP_MODE_SWAP: res = partner;
      SPP_MODE_HSUM: res = half_sum;
      SPP_MODE_HDIFF: res = half_diff;
    endcase
  end

endmodule // spp_pick

// Top level: one channel pair processed per accepted sample.
module spp_core
  import spp_pkg::*;
#(
  parameter int SAMPLE_W = SPP_SAMPLE_W,
  parameter int FIFO_DEPTH = SPP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [SAMPLE_W-1:0] in_left,
  input wire logic signed [SAMPLE_W-1:0] in_right,
  input wire spp_mode_t mode_left,
  input wire spp_mode_t mode_right,
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [SAMPLE_W-1:0] out_left,
  output logic signed [SAMPLE_W-1:0] out_right
);
  localparam int PW = 2 * SAMPLE_W;

  spp_mode_t mode_l_q;
  spp_mode_t mode_r_q;
  logic signed [SAMPLE_W:0] sum_w;
  logic signed [SAMPLE_W:0] diff_w;
  logic signed [SAMPLE_W-1:0] half_sum;
  logic signed [SAMPLE_W-1:0] half_diff;
  logic signed [SAMPLE_W-1:0] res_l;
  logic signed [SAMPLE_W-1:0] res_r;
  logic [PW-1:0] fifo_out;
  logic fifo_in_ready;
  logic take;

  // Back-pressure from the FIFO stalls the source directly.
  assign in_ready = fifo_in_ready;
  assign take = in_valid && fifo_in_ready;

  // Settings are sampled only with an accepted sample so a change can never
  // split one sample between two behaviours.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_l_q <= SPP_MODE_RST;
      mode_r_q <= SPP_MODE_RST;
    end else if (take) begin
      mode_l_q <= mode_left;
      mode_r_q <= mode_right;
    end
  end

  // Modes in effect for the sample being taken now.
  spp_mode_t eff_l;
  spp_mode_t eff_r;
  assign eff_l = take ? mode_left : mode_l_q;
  assign eff_r = take ? mode_right : mode_r_q;

  // One guard bit keeps the full result before the arithmetic halving.
  assign sum_w = {in_left[SAMPLE_W-1], in_left}
    + {in_right[SAMPLE_W-1], in_right};
  assign diff_w = {in_left[SAMPLE_W-1], in_left}
    - {in_right[SAMPLE_W-1], in_right};
  assign half_sum = SAMPLE_W'(sum_w >>> 1);
  assign half_diff = SAMPLE_W'(diff_w >>> 1);

  // Left and right choose independently, so mixed settings never disturb
  // the other channel of the pair; the same halved results feed both.
  spp_pick #(
    .SAMPLE_W(SAMPLE_W)
  ) u_pick_left (
    .mode(eff_l),
    .own(in_left),
    .partner(in_right),
    .half_sum(half_sum),
    .half_diff(half_diff),
    .res(res_l)
  );

  spp_pick #(
    .SAMPLE_W(SAMPLE_W)
  ) u_pick_right (
    .mode(eff_r),
    .own(in_right),
    .partner(in_left),
    .half_sum(half_sum),
    .half_diff(half_diff),
    .res(res_r)
  );

  spp_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(fifo_in_ready),
    .in_data({res_l, res_r}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  // Output samples come from FIFO storage.
  assign out_left = fifo_out[PW-1:SAMPLE_W];
  assign out_right = fifo_out[SAMPLE_W-1:0];

  // Checks on the stream and its arithmetic.
  property p_pass_left;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_PASS |-> res_l == in_left;
  endproperty
  a_pass_left: assert property (p_pass_left)
    else $error("pass-through left altered");

  property p_swap_right;
    @(posedge sys_clk) disable iff (rst)
      take && mode_right == SPP_MODE_SWAP |-> res_r == in_left;
  endproperty
  a_swap_right: assert property (p_swap_right)
    else $error("swap right did not carry left input");

  property p_full_swap;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_SWAP && mode_right == SPP_MODE_SWAP
      |-> res_l == in_right && res_r == in_left;
  endproperty
  a_full_swap: assert property (p_full_swap)
    else $error("full swap not exchanged");

  property p_hsum_both;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HSUM && mode_right == SPP_MODE_HSUM
      |-> res_l == res_r
      && res_l == SAMPLE_W'((int'(in_left) + int'(in_right)) >>> 1);
  endproperty
  a_hsum_both: assert property (p_hsum_both)
    else $error("half-sum outputs differ or wrong");

  property p_hdiff_right;
    @(posedge sys_clk) disable iff (rst)
      take && mode_right == SPP_MODE_HDIFF |->
      res_r == SAMPLE_W'((int'(in_left) - int'(in_right)) >>> 1);
  endproperty
  a_hdiff_right: assert property (p_hdiff_right)
    else $error("half-difference on right not left minus right");

  property p_hdiff_other;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HDIFF && mode_right == SPP_MODE_PASS
      |-> res_r == in_right;
  endproperty
  a_hdiff_other: assert property (p_hdiff_other)
    else $error("partner of half-difference altered");

  property p_hdiff_both;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HDIFF && mode_right == SPP_MODE_HDIFF
      |-> res_l == res_r
      && res_l == SAMPLE_W'((int'(in_left) - int'(in_right)) >>> 1);
  endproperty
  a_hdiff_both: assert property (p_hdiff_both)
    else $error("half-difference outputs differ");

  property p_mode_hold;
    @(posedge sys_clk) disable iff (rst)
      !take |=> mode_l_q == $past(mode_l_q) && mode_r_q == $past(mode_r_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("setting changed without a sample");

  property p_stall;
    @(posedge sys_clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(fifo_out);
  endproperty
  a_stall: assert property (p_stall)
    else $error("output changed while stalled");

  // Reference values here use int arithmetic, which limits these checks to
  // sample widths of 31 bits or less.
  property p_pass_right;
    @(posedge sys_clk) disable iff (rst)
      take && mode_right == SPP_MODE_PASS |-> res_r == in_right;
  endproperty
  a_pass_right: assert property (p_pass_right)
    else $error("pass-through right altered");

  property p_swap_left;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_SWAP && mode_right == SPP_MODE_PASS
      |-> res_l == in_right && res_r == in_right;
  endproperty
  a_swap_left: assert property (p_swap_left)
    else $error("swap left or its pass-through partner wrong");

  property p_hsum_left;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HSUM |->
      res_l == SAMPLE_W'((int'(in_left) + int'(in_right)) >>> 1);
  endproperty
  a_hsum_left: assert property (p_hsum_left)
    else $error("half-sum on left wrong");

  property p_hsum_other;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HSUM && mode_right == SPP_MODE_PASS
      |-> res_r == in_right;
  endproperty
  a_hsum_other: assert property (p_hsum_other)
    else $error("partner of half-sum altered");

  property p_hdiff_left;
    @(posedge sys_clk) disable iff (rst)
      take && mode_left == SPP_MODE_HDIFF |->
      res_l == SAMPLE_W'((int'(in_left) - int'(in_right)) >>> 1);
  endproperty
  a_hdiff_left: assert property (p_hdiff_left)
    else $error("half-difference on left wrong");

  property p_mode_take;
    @(posedge sys_clk) disable iff (rst)
      take |=> mode_l_q == $past(mode_left)
      && mode_r_q == $past(mode_right);
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("setting not taken with its sample");

  // A pair entering an empty buffer shows up whole on the next cycle.
  property p_answer;
    @(posedge sys_clk) disable iff (rst)
      take && !out_valid |=> out_valid && out_left == $past(res_l)
      && out_right == $past(res_r);
  endproperty
  a_answer: assert property (p_answer)
    else $error("pair not delivered whole after one cycle");

  c_full: cover property (@(posedge sys_clk) disable iff (rst) !in_ready);
  c_swap: cover property (@(posedge sys_clk) disable iff (rst)
    take && mode_left == SPP_MODE_SWAP && mode_right == SPP_MODE_SWAP);
  c_hsum: cover property (@(posedge sys_clk) disable iff (rst)
    take && mode_left == SPP_MODE_HSUM);
  c_hdiff: cover property (@(posedge sys_clk) disable iff (rst)
    take && mode_right == SPP_MODE_HDIFF);

endmodule // spp_core

// ===== pkg/spp_pkg.sv
// Package with constants and types for the stereo pair processor.
// Contract
// - Audio is only ever combined or exchanged between the two channels of one adjacent pair.
// - The first channel of each pair is always processed as left and the second as right.
// - A channel set to pass-through carries its own input audio unchanged.
// - A channel set to swap carries its partner's input, while a pass-through partner keeps its own.
// - With both channels of a pair set to swap, the two inputs are fully exchanged.
// - A channel set to half-sum carries (L+R)/2 and its partner is unaffected by that setting.
// - With both channels set to half-sum, both carry the same (L+R)/2.
// - A channel set to half-difference carries (L-R)/2.
// - The second channel set to half-difference still carries left minus right, halved.
// - When only one channel selects half-difference, the other channel is left untouched.
// - With both channels set to half-difference, both carry the same (L-R)/2.
// - Every channel offers the same four choices, selected per channel.
package spp_pkg;

  // Default sample width, pair count and output FIFO depth.
  localparam int SPP_SAMPLE_W = 24;
  localparam int SPP_PAIRS = 2;
  localparam int SPP_FIFO_DEPTH = 16;

  // Four per-channel behaviours, encoded on two bits.
  typedef enum logic [1:0] {
    SPP_MODE_PASS,
    SPP_MODE_SWAP,
    SPP_MODE_HSUM,
    SPP_MODE_HDIFF
  } spp_mode_t;

  // Reset value of every channel setting.
  localparam spp_mode_t SPP_MODE_RST = SPP_MODE_PASS;

  // One processed pair as carried through the output FIFO.
  typedef struct packed {
    logic signed [SPP_SAMPLE_W-1:0] left;
    logic signed [SPP_SAMPLE_W-1:0] right;
  } spp_pair_t;

endpackage

// ===== tb/spp_core_tb.sv
// Self-checking testbench for the stereo pair processor.
`timescale 1ns/1ps
module spp_core_tb
  import spp_pkg::*;
;
  typedef logic signed [SPP_SAMPLE_W-1:0] spp_smp_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic in_ready;
  spp_smp_t in_left = '0;
  spp_smp_t in_right = '0;
  spp_mode_t mode_left = SPP_MODE_PASS;
  spp_mode_t mode_right = SPP_MODE_PASS;
  logic out_valid;
  logic out_ready;
  spp_smp_t out_left;
  spp_smp_t out_right;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int n_errors = 0;
  int comparisons = 0;

  spp_core #(.SAMPLE_W(SPP_SAMPLE_W), .FIFO_DEPTH(SPP_FIFO_DEPTH)) i_spp_core (
    .sys_clk(sys_clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .in_left(in_left), .in_right(in_right), .mode_left(mode_left),
    .mode_right(mode_right), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right));
  spp_sink i_spp_sink (.sys_clk(sys_clk), .rst(rst), .stall(stall),
    .slow(slow), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right));

  // The 25 MHz clock.
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(string name, spp_smp_t seen, spp_smp_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reference result; the extra bit keeps the sum from wrapping.
  function automatic spp_smp_t model(spp_mode_t m, spp_smp_t own,
      spp_smp_t prt, spp_smp_t l, spp_smp_t r);
    logic signed [SPP_SAMPLE_W:0] s;
    logic signed [SPP_SAMPLE_W:0] d;
    s = l + r;
    d = l - r;
    case (m)
      SPP_MODE_SWAP: return prt;
      SPP_MODE_HSUM: return spp_smp_t'(s >>> 1);
      SPP_MODE_HDIFF: return spp_smp_t'(d >>> 1);
      default: return own;
    endcase
  endfunction

  // Offers one pair and returns at the edge that takes it; valid stays up.
  task automatic send(spp_smp_t l, spp_smp_t r, spp_mode_t ml, spp_mode_t mr);
    logic ok;
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    mode_left <= ml;
    mode_right <= mr;
    do begin
      @(negedge sys_clk);
      ok = in_ready;
      @(posedge sys_clk);
    end while (ok !== 1'b1);
  endtask

  // Waits a bounded time for the sink to hold a pair.
  task automatic pop(output spp_pair_t p);
    int n;
    n = 0;
    while (i_spp_sink.got_q.size() == 0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    p = (n < 200) ? i_spp_sink.got_q.pop_front() : 'x;
  endtask

  // All sixteen setting pairs back to back, settings changing every sample.
  task automatic t_modes();
    spp_pair_t p;
    spp_smp_t l;
    spp_smp_t r;
    slow <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      send(24'h300000 - i * 24'h0F0F1, -(i * 24'h21001),
        spp_mode_t'(i / 4), spp_mode_t'(i % 4));
    end
    in_valid <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      l = 24'h300000 - i * 24'h0F0F1;
      r = -(i * 24'h21001);
      pop(p);
      chk("left", p.left, model(spp_mode_t'(i / 4), l, r, l, r));
      chk("right", p.right, model(spp_mode_t'(i % 4), r, l, l, r));
    end
    slow <= 1'b0;
  endtask

  // Extreme values, where a narrow adder or wrong order would show.
  task automatic t_limits();
    spp_pair_t p;
    send(24'h7FFFFF, 24'h7FFFFF, SPP_MODE_HSUM, SPP_MODE_HSUM);
    send(24'h7FFFFF, 24'h800000, SPP_MODE_PASS, SPP_MODE_HDIFF);
    send(24'h800000, 24'h000003, SPP_MODE_SWAP, SPP_MODE_HSUM);
    in_valid <= 1'b0;
    pop(p);
    chk("sum_l", p.left, 24'h7FFFFF);
    chk("sum_r", p.right, 24'h7FFFFF);
    pop(p);
    chk("keep_l", p.left, 24'h7FFFFF);
    chk("diff_r", p.right, 24'h7FFFFF);
    pop(p);
    chk("swap_l", p.left, 24'h000003);
    chk("sum_r", p.right, 24'hC00001);
  endtask

  // Fill the buffer with the sink stalled, see it refuse, then drain it.
  task automatic t_fill();
    spp_pair_t p;
    stall <= 1'b1;
    for (int i = 0; i < SPP_FIFO_DEPTH; i++) begin
      send(i, ~i, SPP_MODE_PASS, SPP_MODE_SWAP);
    end
    @(negedge sys_clk);
    chk("full", spp_smp_t'(in_ready), 24'h000000);
    @(posedge sys_clk);
    in_valid <= 1'b0;
    stall <= 1'b0;
    for (int i = 0; i < SPP_FIFO_DEPTH; i++) begin
      pop(p);
      chk("fill_l", p.left, i);
      chk("fill_r", p.right, i);
    end
    repeat (4) @(posedge sys_clk);
    chk("extra", i_spp_sink.got_q.size(), 0);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("rst_valid", spp_smp_t'(out_valid), 24'h000000);
    @(posedge sys_clk);
    t_modes();
    t_limits();
    t_fill();
    end_sim();
  end

  // The run needs well under a thousand cycles; this cuts off a hang.
  initial begin
    #(40 * 20000);
    n_errors++;
    $display("Error watchdog expired");
    end_sim();
  end
endmodule // spp_core_tb

// ===== tb/spp_sink.sv
// Routing matrix model that takes processed pairs from the block.
`timescale 1ns/1ps
module spp_sink
  import spp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic slow,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic signed [SPP_SAMPLE_W-1:0] out_left,
  input wire logic signed [SPP_SAMPLE_W-1:0] out_right
);
  spp_pair_t got_q[$];
  logic tick_q;

  // Slow mode drops ready every other cycle, like a busy matrix would.
  assign out_ready = !stall && (!slow || tick_q);

  // Every pair taken is kept in arrival order for the bench to judge.
  always @(posedge sys_clk) begin
    tick_q <= rst ? 1'b0 : !tick_q;
    if (!rst && out_valid && out_ready) begin
      got_q.push_back('{left: out_left, right: out_right});
    end
  end
endmodule // spp_sink
